// File: src/swrc_top.sv
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "swrc_map.svh"
module swrc_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog and pin inputs
    input wire logic reset_pin_n,
    input wire logic [3:0] por_level_ok,
    input wire logic [2:0] supply_below,
    input wire logic clk_src_ready,
    // same-clock sources
    input wire logic wdt_reset,
    input wire logic wdt_lrc_req,
    input wire logic irq_accepted,
    input wire logic ext_irq_zero,
    input wire logic ext_irq_one,
    input wire logic ext_irq_two,
    input wire logic ext_irq_four,
    input wire logic port0_irq,
    input wire logic base_timer_irq,
    // gating outputs
    output logic sys_reset,
    output logic cpu_run,
    output logic periph_en,
    output logic base_timer_en,
    output logic ceramic_osc_en,
    output logic xtal_osc_en,
    output logic rc_osc_en,
    output logic mrc_osc_en,
    output logic frc_osc_en,
    output logic lrc_osc_en
);
    function automatic logic pick(input logic [3:0] v, input logic [1:0] i);
        pick = v[i];
    endfunction : pick

    // two-flop synchronisers
    logic [8:0] sync1_reg;
    logic [8:0] sync2_reg;
    always_ff @(posedge aclk) begin
        sync1_reg <= {clk_src_ready, supply_below, por_level_ok, reset_pin_n};
        sync2_reg <= sync1_reg;
    end
    wire pin_n_s = sync2_reg[0];
    wire [3:0] por_ok_s = sync2_reg[4:1];
    wire [3:0] below_s = {1'b0, sync2_reg[7:5]};
    wire clk_ok_s = sync2_reg[8];

    logic [7:0] osc_reg;
    logic [1:0] wake_reg;
    logic [4:0] opt_reg;
    logic [1:0] cause_reg;
    logic por_hold_reg;
    swrc_pkg::swrc_state_t st_reg;
    swrc_pkg::swrc_state_t st_next;

    wire [1:0] por_sel = opt_reg[`SWRC_OPT_POR_HI:`SWRC_OPT_POR_LO];
    wire [1:0] drop_sel = opt_reg[`SWRC_OPT_DROP_HI:`SWRC_OPT_DROP_LO];
    wire [2:0] clk_sel = osc_reg[`SWRC_OSC_SEL_HI:`SWRC_OSC_SEL_LO];
    wire drop_trip = opt_reg[`SWRC_OPT_DROP_EN] & pick(below_s, drop_sel);
    wire sys_rst_w = por_hold_reg | drop_trip | wdt_reset | ~pin_n_s;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_hold_reg <= 1'b1;
        end else if (pick(por_ok_s, por_sel)) begin
            por_hold_reg <= 1'b0;
        end
    end

    // level-only wake for irq 0 and 1
    wire hold_src = (ext_irq_zero & wake_reg[`SWRC_WAKE_LVL0])
        | (ext_irq_one & wake_reg[`SWRC_WAKE_LVL1])
        | ext_irq_two | ext_irq_four | port0_irq;
    // base timer wake needs crystal clock
    wire xhold_src = hold_src
        | (base_timer_irq & (clk_sel == `SWRC_SEL_XTAL));

    // bus write path
    logic aw_full_reg;
    logic w_full_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic w_lane_reg;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire do_wr = aw_full_reg & w_full_reg & ~s_axi_bvalid;
    wire wr_en = do_wr & w_lane_reg;
    wire wr_osc = wr_en & (aw_addr_reg == `SWRC_OFF_OSC);
    wire wr_wake = wr_en & (aw_addr_reg == `SWRC_OFF_WAKE);
    wire wr_opt = wr_en & (aw_addr_reg == `SWRC_OFF_OPT);
    wire wr_stby = wr_en & (aw_addr_reg == `SWRC_OFF_STBY);
    wire wr_hit = (aw_addr_reg == `SWRC_OFF_OSC)
        | (aw_addr_reg == `SWRC_OFF_WAKE) | (aw_addr_reg == `SWRC_OFF_OPT)
        | (aw_addr_reg == `SWRC_OFF_STBY) | (aw_addr_reg == `SWRC_OFF_STAT);
    wire [1:0] cmd = w_data_reg[1:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_lane_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SWRC_RESP_OKAY;
        end else begin
            s_axi_awready <= s_axi_awvalid & ~aw_full_reg & ~s_axi_awready;
            s_axi_wready <= s_axi_wvalid & ~w_full_reg & ~s_axi_wready;
            if (aw_take) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_take) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_lane_reg <= s_axi_wstrb[0];
            end
            if (do_wr) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `SWRC_RESP_OKAY : `SWRC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_reg <= `SWRC_OSC_RST;
            wake_reg <= `SWRC_WAKE_RST;
            opt_reg <= `SWRC_OPT_RST;
        end else begin
            // system reset stops ceramic and crystal
            if (sys_rst_w) begin
                osc_reg <= `SWRC_OSC_RST;
            end else if (wr_osc) begin
                osc_reg <= w_data_reg[7:0];
            end
            if (wr_wake) begin
                wake_reg <= w_data_reg[1:0];
            end
            if (wr_opt) begin
                opt_reg <= w_data_reg[4:0];
            end
        end
    end

    // reset cause latch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cause_reg <= `SWRC_CAUSE_POR;
        end else if (~pin_n_s) begin
            cause_reg <= `SWRC_CAUSE_PIN;
        end else if (drop_trip) begin
            cause_reg <= `SWRC_CAUSE_DROP;
        end else if (wdt_reset) begin
            cause_reg <= `SWRC_CAUSE_WDT;
        end
    end

    // standby state machine
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            swrc_pkg::ST_RUN: begin
                if (wr_stby && cmd == `SWRC_CMD_HALT) begin
                    st_next = swrc_pkg::ST_HALT;
                end else if (wr_stby && cmd == `SWRC_CMD_HOLD) begin
                    st_next = swrc_pkg::ST_HOLD;
                end else if (wr_stby && cmd == `SWRC_CMD_XHOLD) begin
                    st_next = swrc_pkg::ST_XHOLD;
                end
            end
            swrc_pkg::ST_HALT: begin
                if (irq_accepted) begin
                    st_next = swrc_pkg::ST_RUN;
                end
            end
            swrc_pkg::ST_HOLD: begin
                if (hold_src) begin
                    st_next = swrc_pkg::ST_WAKE;
                end
            end
            swrc_pkg::ST_XHOLD: begin
                if (xhold_src) begin
                    st_next = swrc_pkg::ST_WAKE;
                end
            end
            swrc_pkg::ST_WAKE: begin
                if (clk_ok_s) begin
                    st_next = swrc_pkg::ST_RUN;
                end
            end
            default: begin
                st_next = swrc_pkg::ST_RUN;
            end
        endcase
        if (sys_rst_w) begin
            st_next = swrc_pkg::ST_RUN;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= swrc_pkg::ST_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    // gating decode
    wire in_run = (st_reg == swrc_pkg::ST_RUN);
    wire in_halt = (st_reg == swrc_pkg::ST_HALT);
    wire in_hold = (st_reg == swrc_pkg::ST_HOLD);
    wire in_xhold = (st_reg == swrc_pkg::ST_XHOLD);
    // fast oscillators stop in both holds
    wire stop_fast = in_hold | in_xhold;
    // crystal stops in full hold and on system reset
    wire stop_xtal = in_hold | sys_rst_w;
    wire run_next = in_run & ~sys_rst_w;
    wire periph_next = (in_run | in_halt) & ~sys_rst_w;
    // base timer counts in crystal hold
    wire bt_next = (in_run | in_halt | in_xhold) & ~sys_rst_w;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_reset <= 1'b1;
            cpu_run <= 1'b0;
            periph_en <= 1'b0;
            base_timer_en <= 1'b0;
            ceramic_osc_en <= 1'b0;
            xtal_osc_en <= 1'b0;
            rc_osc_en <= 1'b0;
            mrc_osc_en <= 1'b0;
            frc_osc_en <= 1'b0;
            lrc_osc_en <= 1'b0;
        end else begin
            sys_reset <= sys_rst_w;
            cpu_run <= run_next;
            periph_en <= periph_next;
            base_timer_en <= bt_next;
            ceramic_osc_en <= osc_reg[`SWRC_OSC_CER] & ~stop_fast & ~sys_rst_w;
            xtal_osc_en <= osc_reg[`SWRC_OSC_XTAL] & ~stop_xtal;
            rc_osc_en <= osc_reg[`SWRC_OSC_RC] & ~stop_fast;
            mrc_osc_en <= osc_reg[`SWRC_OSC_MRC] & ~stop_fast;
            frc_osc_en <= osc_reg[`SWRC_OSC_FRC] & ~stop_fast;
            lrc_osc_en <= wdt_lrc_req;
        end
    end

    // bus read path
    logic [31:0] rd_word;
    logic rd_hit;
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            `SWRC_OFF_OSC: rd_word = {24'h00_0000, osc_reg};
            `SWRC_OFF_WAKE: rd_word = {30'h0000_0000, wake_reg};
            `SWRC_OFF_OPT: rd_word = {27'h000_0000, opt_reg};
            `SWRC_OFF_STBY: rd_word = {29'h0000_0000, st_reg};
            `SWRC_OFF_STAT: rd_word = {27'h000_0000, clk_ok_s, cause_reg,
                ~por_hold_reg, sys_rst_w};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SWRC_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `SWRC_RESP_OKAY : `SWRC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_back_to_run;
        st_reg == swrc_pkg::ST_RUN && cpu_run;
    endsequence
    sequence s_resume_clean;
        !sys_rst_w ##1 !sys_rst_w;
    endsequence

    a_por_only_once: assert property (
        !por_hold_reg |=> !por_hold_reg)
        else $error("power-on hold came back");
    a_drop_forces_reset: assert property (
        drop_trip |=> sys_reset && !cpu_run)
        else $error("supply drop did not reset");
    a_halt_gates_cpu: assert property (
        in_halt && !sys_rst_w |=> !cpu_run && periph_en)
        else $error("halt gating wrong");
    a_halt_keeps_osc: assert property (
        in_halt && !sys_rst_w |=> rc_osc_en == $past(osc_reg[`SWRC_OSC_RC]))
        else $error("halt touched an oscillator");
    a_halt_irq_exit: assert property (
        in_halt && irq_accepted && !sys_rst_w ##0 s_resume_clean
        |=> s_back_to_run)
        else $error("halt did not end on interrupt");
    a_hold_stops_all: assert property (
        in_hold |=> !periph_en && !xtal_osc_en && !ceramic_osc_en
        && !rc_osc_en && !mrc_osc_en && !frc_osc_en)
        else $error("hold left something running");
    a_lrc_follows_wdt: assert property (
        wdt_lrc_req |=> lrc_osc_en)
        else $error("low-speed rc ignored watchdog");
    a_edge_no_wake: assert property (
        in_hold && !hold_src && !sys_rst_w |=> in_hold)
        else $error("hold left without a wake source");
    a_hold_wake: assert property (
        in_hold && hold_src && !sys_rst_w
        |=> st_reg == swrc_pkg::ST_WAKE)
        else $error("hold did not wake");
    a_xhold_btimer: assert property (
        in_xhold && !sys_rst_w |=> base_timer_en && !periph_en && !cpu_run)
        else $error("crystal hold gating wrong");
    a_xhold_xtal_kept: assert property (
        in_xhold && !sys_rst_w
        |=> xtal_osc_en == $past(osc_reg[`SWRC_OSC_XTAL]))
        else $error("crystal state not kept");
    a_btimer_gate: assert property (
        in_xhold && !hold_src && base_timer_irq
        && clk_sel != `SWRC_SEL_XTAL && !sys_rst_w |=> in_xhold)
        else $error("base timer woke without crystal clock");
    a_reset_stops_osc: assert property (
        sys_rst_w |=> !ceramic_osc_en && !xtal_osc_en
        && !osc_reg[`SWRC_OSC_CER] && !osc_reg[`SWRC_OSC_XTAL])
        else $error("reset left ceramic or crystal on");
    a_wake_resume: assert property (
        st_reg == swrc_pkg::ST_WAKE && clk_ok_s ##0 s_resume_clean
        |=> s_back_to_run)
        else $error("no resume after clock ready");
endmodule : swrc_top

// File: src/swrc_map.svh
`ifndef SWRC_MAP_SVH
`define SWRC_MAP_SVH
// register byte offsets
`define SWRC_OFF_OSC 8'h00
`define SWRC_OFF_WAKE 8'h04
`define SWRC_OFF_OPT 8'h08
`define SWRC_OFF_STBY 8'h0C
`define SWRC_OFF_STAT 8'h10
// oscillator control fields
`define SWRC_OSC_CER 0
`define SWRC_OSC_XTAL 1
`define SWRC_OSC_RC 2
`define SWRC_OSC_MRC 3
`define SWRC_OSC_FRC 4
`define SWRC_OSC_SEL_HI 7
`define SWRC_OSC_SEL_LO 5
`define SWRC_OSC_RST 8'h24
`define SWRC_SEL_XTAL 3'h4
// wake config fields
`define SWRC_WAKE_LVL0 0
`define SWRC_WAKE_LVL1 1
`define SWRC_WAKE_RST 2'h0
// option fields
`define SWRC_OPT_POR_HI 1
`define SWRC_OPT_POR_LO 0
`define SWRC_OPT_DROP_EN 2
`define SWRC_OPT_DROP_HI 4
`define SWRC_OPT_DROP_LO 3
`define SWRC_OPT_RST 5'h00
// standby codes
`define SWRC_CMD_HALT 2'h1
`define SWRC_CMD_HOLD 2'h2
`define SWRC_CMD_XHOLD 2'h3
// reset causes
`define SWRC_CAUSE_POR 2'h0
`define SWRC_CAUSE_PIN 2'h1
`define SWRC_CAUSE_DROP 2'h2
`define SWRC_CAUSE_WDT 2'h3
// bus answers
`define SWRC_RESP_OKAY 2'h0
`define SWRC_RESP_SLVERR 2'h2
`endif

// File: src/swrc_pkg.sv
package swrc_pkg;
    typedef enum logic [2:0] {
        ST_RUN,
        ST_HALT,
        ST_HOLD,
        ST_XHOLD,
        ST_WAKE
    } swrc_state_t;
endpackage : swrc_pkg

// File: verification/swrc_far_model.sv
`timescale 1ns/1ns
module swrc_far_model (
    // clock and answer speed
    input wire logic aclk,
    input wire logic slow,
    // oscillator enables from the block
    input wire logic [4:0] osc_en,
    // any enabled source running
    output logic clk_src_ready
);
    logic [3:0] cnt;
    // source needs a startup delay before it counts as running
    always_ff @(posedge aclk) begin
        if (osc_en == 5'h00) begin
            cnt <= 4'h0;
            clk_src_ready <= 1'b0;
        end else if (cnt != (slow ? 4'hc : 4'h1)) begin
            cnt <= cnt + 4'h1;
        end else begin
            clk_src_ready <= 1'b1;
        end
    end
endmodule : swrc_far_model

// File: verification/swrc_bench.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
    err_count++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module standby_wakeup_reset_control_bench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, reset_pin_n;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, por_level_ok;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [2:0] supply_below;
    logic clk_src_ready, wdt_reset, wdt_lrc_req, irq_accepted, slow;
    logic ext_irq_zero, ext_irq_one, ext_irq_two, ext_irq_four;
    logic port0_irq, base_timer_irq, sys_reset, cpu_run, periph_en;
    logic base_timer_en, ceramic_osc_en, xtal_osc_en, rc_osc_en;
    logic mrc_osc_en, frc_osc_en, lrc_osc_en;
    logic [4:0] oscv;
    integer seed, err_count, check_count, i;
    assign oscv = {frc_osc_en, mrc_osc_en, rc_osc_en, xtal_osc_en,
        ceramic_osc_en};
    swrc_top i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .reset_pin_n(reset_pin_n),
        .por_level_ok(por_level_ok), .supply_below(supply_below),
        .clk_src_ready(clk_src_ready), .wdt_reset(wdt_reset),
        .wdt_lrc_req(wdt_lrc_req), .irq_accepted(irq_accepted),
        .ext_irq_zero(ext_irq_zero), .ext_irq_one(ext_irq_one),
        .ext_irq_two(ext_irq_two), .ext_irq_four(ext_irq_four),
        .port0_irq(port0_irq), .base_timer_irq(base_timer_irq),
        .sys_reset(sys_reset), .cpu_run(cpu_run), .periph_en(periph_en),
        .base_timer_en(base_timer_en), .ceramic_osc_en(ceramic_osc_en),
        .xtal_osc_en(xtal_osc_en), .rc_osc_en(rc_osc_en),
        .mrc_osc_en(mrc_osc_en), .frc_osc_en(frc_osc_en),
        .lrc_osc_en(lrc_osc_en));
    swrc_far_model i_far (.aclk(aclk), .slow(slow), .osc_en(oscv),
        .clk_src_ready(clk_src_ready));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task wrap_up;
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task axi_wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 50) begin
            err_count++;
            wrap_up;
        end
    endtask : axi_wr
    task axi_rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 50) begin
            err_count++;
            wrap_up;
        end
    endtask : axi_rd
    task wait_out(input logic sel_sys, input logic v);
        int n;
        n = 0;
        while ((sel_sys ? sys_reset : cpu_run) !== v && n < 80) begin
            @(posedge aclk);
            n++;
        end
        `CHK("wait_out", v, (sel_sys ? sys_reset : cpu_run))
        if (n >= 80) wrap_up;
    endtask : wait_out
    // oscillator enables expected in each standby code
    function automatic logic [4:0] osc_exp(input logic [1:0] m,
        input logic [7:0] o);
        case (m)
            2'h2: osc_exp = 5'h00;
            2'h3: osc_exp = {3'h0, o[1], 1'b0};
            default: osc_exp = o[4:0];
        endcase
    endfunction : osc_exp
    task enter(input logic [1:0] m, input logic [7:0] o);
        logic [1:0] r;
        axi_wr(8'h00, {24'h00_0000, o}, r);
        axi_wr(8'h0c, {30'h0000_0000, m}, r);
        cyc(3);
        `CHK("cpu_run", 1'b0, cpu_run)
        `CHK("periph_en", m == 2'h1, periph_en)
        `CHK("base_timer_en", m != 2'h2, base_timer_en)
        `CHK("osc_en", osc_exp(m, o), oscv)
        `CHK("lrc_osc_en", wdt_lrc_req, lrc_osc_en)
    endtask : enter
    initial begin
        seed = 32'h5e86;
        err_count = 0;
        check_count = 0;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, wdt_reset, irq_accepted} = 4'h0;
        {ext_irq_zero, ext_irq_one, ext_irq_two, ext_irq_four} = 4'h0;
        {port0_irq, base_timer_irq, wdt_lrc_req, slow} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
        s_axi_wstrb = 4'hf;
        reset_pin_n = 1'b1;
        por_level_ok = 4'h0;
        supply_below = 3'h0;
        cyc(10);
        aresetn <= 1'b1;
        cyc(10);
        `CHK("sys_reset", 1'b1, sys_reset)
        por_level_ok <= 4'h1;
        wait_out(1'b1, 1'b0);
        wait_out(1'b0, 1'b1);
        axi_rd(8'h00, rd, rsp);
        `CHK("osc_reg", 32'h0000_0024, rd)
        axi_rd(8'h14, rd, rsp);
        `CHK("rresp", 2'h2, rsp)
        axi_wr(8'h14, 32'h0000_0000, rsp);
        `CHK("bresp", 2'h2, rsp)
        // power-on reset does not return later
        por_level_ok <= 4'h0;
        cyc(8);
        `CHK("sys_reset", 1'b0, sys_reset)
        por_level_ok <= 4'hf;
        for (i = 0; i < 8; i++) begin
            wdt_lrc_req <= 1'($random(seed));
            cyc(2);
            `CHK("lrc_osc_en", wdt_lrc_req, lrc_osc_en)
        end
        enter(2'h1, 8'h3f);
        irq_accepted <= 1'b1;
        cyc(1);
        irq_accepted <= 1'b0;
        wait_out(1'b0, 1'b1);
        // edge-mode irq one must not wake hold
        wdt_lrc_req <= 1'b1;
        enter(2'h2, 8'h3f);
        ext_irq_one <= 1'b1;
        cyc(10);
        `CHK("cpu_run", 1'b0, cpu_run)
        axi_wr(8'h04, 32'h0000_0002, rsp);
        wait_out(1'b0, 1'b1);
        ext_irq_one <= 1'b0;
        axi_wr(8'h04, 32'h0000_0001, rsp);
        for (i = 0; i < 4; i++) begin
            slow <= 1'($random(seed));
            enter(2'h2, {3'h1, 5'($random(seed))} | 8'h04);
            case (i)
                0: ext_irq_zero <= 1'b1;
                1: ext_irq_two <= 1'b1;
                2: ext_irq_four <= 1'b1;
                default: port0_irq <= 1'b1;
            endcase
            wait_out(1'b0, 1'b1);
            {ext_irq_zero, ext_irq_two, ext_irq_four, port0_irq} <= 4'h0;
        end
        // base timer ignored unless the crystal is the clock
        enter(2'h3, 8'h26);
        base_timer_irq <= 1'b1;
        cyc(10);
        `CHK("cpu_run", 1'b0, cpu_run)
        `CHK("xtal_osc_en", 1'b1, xtal_osc_en)
        base_timer_irq <= 1'b0;
        ext_irq_two <= 1'b1;
        wait_out(1'b0, 1'b1);
        ext_irq_two <= 1'b0;
        enter(2'h3, 8'h86);
        base_timer_irq <= 1'b1;
        wait_out(1'b0, 1'b1);
        base_timer_irq <= 1'b0;
        // pin, supply drop and watchdog reset each end halt and stop ceramic and crystal
        axi_wr(8'h08, 32'h0000_0004, rsp);
        for (i = 0; i < 3; i++) begin
            enter(2'h1, 8'h3f);
            reset_pin_n <= (i != 0);
            supply_below <= {2'h0, i == 1};
            wdt_reset <= (i == 2);
            wait_out(1'b1, 1'b1);
            cyc(3);
            `CHK("ceramic_osc_en", 1'b0, ceramic_osc_en)
            `CHK("xtal_osc_en", 1'b0, xtal_osc_en)
            reset_pin_n <= 1'b1;
            supply_below <= 3'h0;
            wdt_reset <= 1'b0;
            wait_out(1'b0, 1'b1);
            axi_rd(8'h10, rd, rsp);
            `CHK("cause", 2'(i + 1), rd[3:2])
            axi_rd(8'h00, rd, rsp);
            `CHK("osc_reg", 32'h0000_0024, rd)
        end
        wrap_up;
    end
    initial begin
        cyc(50000);
        err_count++;
        wrap_up;
    end
endmodule : standby_wakeup_reset_control_bench
